// ==== design/aqt_core.sv ====
/*
  Storage qualification, capture address counter, occurrence counter,
  counter/timer and trigger control of a 24-channel acquisition module, with
  a classic Wishbone slave for the host. Assumes probe data arrives already
  captured and synchronous to clk_i, and that the acquisition memory is
  written at capture_addr_bits_o whenever mem_we_o is high on a clock edge.
*/
// Summary of operation
// R1 - Paired-window select makes reset word a start and alternate word a stop.
// R2 - Trigger side receives an active-low copy of the paired-window select.
// R3 - Low storage-stop output blocks writing samples into capture memory.
// R4 - High storage-start output allows samples to be written to memory.
// R5 - Each word recognizer is high while probes match its programmed pattern.
// R6 - Low address-advance enable increments the address counter next clock.
// R7 - Host presets address counter: low 8 bits and upper 2 bits separately.
// R8 - Address counter is 10 bits and directly addresses capture memory.
// R9 - Reads return low address bits, or high bits, storing, full, stack level.
// R10 - In readback, address advances only after the post-trigger delay ends.
// R11 - Counter-clear strobe clears all counter/timer stages to zero.
// R12 - Both selects high means timer; first low, second high means counter.
// R13 - Timer mode sets a readable restart flag when the count is reset.
// R14 - Interrupt-clear strobe clears the restart flag and the interrupt latch.
// R15 - Interrupt request only with gate high and counter or timer selected.
// R16 - Stack recognizer stays inactive until the external arm input is seen.
// R17 - First-sample strobe goes out only in solo configuration.
// R18 - Block-stack control stops stack triggering, alternate trigger unaffected.
// R19 - In normal mode a reset event reloads the level-0 occurrence count.
// R20 - Occurrence counts are written as low 8 bits and upper 4 bits.
// R21 - Load strobe copies stored count into counter; diagnostic step clocks it.
// R22 - Normal mode: alternate word triggers; paired mode: it stops storage.
// R23 - Storing state holds from a start condition until a stop word.
// R24 - In normal mode a reset word returns the stack level to zero.
// R25 - Memory-full flag sets the clock after a sample is written at full count.
// R26 - All state updates synchronously on the single module clock.
`timescale 1ns/1ps
`include "aqt_map.svh"

module aqt_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire aqt_pkg::aqt_wb_req_t wb_req_i,
  output aqt_pkg::aqt_wb_rsp_t wb_rsp_o,
  input wire logic [`AQT_PROBE_W-1:0] probe_data_i,
  input wire logic external_arm_input_i,
  output logic [`AQT_ADDR_W-1:0] capture_addr_bits_o,
  output logic mem_we_o,
  output logic storage_start_o,
  output logic storage_stop_n_o,
  output logic capture_addr_advance_n_o,
  output logic paired_window_to_trigger_n_o,
  output logic alt_trigger_qual_n_o,
  output logic reload_level0_count_n_o,
  output logic first_sample_o,
  output logic triggered_o,
  output logic irq_request_n_o
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  function automatic logic word_hit(input logic [`AQT_PROBE_W-1:0] probe,
                                    input logic [`AQT_PROBE_W-1:0] pat,
                                    input logic [`AQT_PROBE_W-1:0] care);
    word_hit = ((probe ^ pat) & care) == '0;
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  // ==========================================================================
  // State and combinational terms
  // ==========================================================================
  aqt_pkg::aqt_state_t s_q, s_d;

  logic run, pw, pw_n, solo, timer_mode, counter_mode, ct_on;
  logic start_hit, stop_hit, reset_hit, alt_hit, stack_match;
  logic start_cond, stop_cond, write_en, advance, armed, normal;
  logic reset_evt, stack_hit, stack_trig, alt_trig, load_lo, load_hi;
  logic req, do_wr, count_inc, restart_evt, overflow;
  logic [31:0] wdat, mrg;
  logic [`AQT_LVL_W-1:0] widx, next_lvl;

  always_comb begin
    s_d = s_q;
    run = s_q.ctrl[`AQT_CTRL_RUN];
    pw = s_q.ctrl[`AQT_CTRL_PW];
    pw_n = !pw; // R2
    normal = pw_n;
    solo = s_q.ctrl[`AQT_CTRL_SOLO];
    timer_mode = s_q.ctrl[`AQT_CTRL_SEL_A] && s_q.ctrl[`AQT_CTRL_SEL_B]; // R12
    counter_mode = !s_q.ctrl[`AQT_CTRL_SEL_A] && s_q.ctrl[`AQT_CTRL_SEL_B]; // R12
    ct_on = timer_mode || counter_mode;

    // Word recognizers follow the probes combinationally.
    start_hit = word_hit(probe_data_i, s_q.pat_start, s_q.care); // R5
    stop_hit = word_hit(probe_data_i, s_q.pat_stop, s_q.care); // R5
    reset_hit = word_hit(probe_data_i, s_q.pat_reset, s_q.care); // R5
    alt_hit = word_hit(probe_data_i, s_q.pat_alt, s_q.care); // R5
    stack_match = word_hit(probe_data_i, s_q.pat_stack, s_q.care);

    // ========================================================================
    // Storage qualification
    // ========================================================================
    start_cond = run && (start_hit || (pw && reset_hit)); // R1
    stop_cond = run && (stop_hit || (pw && alt_hit)); // R1 R22
    // Stop beats start so that a window closes even on a shared sample.
    write_en = (s_q.storing || start_cond) && !stop_cond; // R3 R4 R23
    s_d.storing = write_en; // R23
    armed = s_q.phase == aqt_pkg::AQT_PH_ARMED;
    advance = write_en ||
              (s_q.ctrl[`AQT_CTRL_MEM_READ] && s_q.phase == aqt_pkg::AQT_PH_DONE); // R10

    // ========================================================================
    // Register bus
    // ========================================================================
    req = wb_req_i.cyc && wb_req_i.stb;
    // Writes land on the edge where the master sees ack, never earlier.
    do_wr = req && wb_req_i.we && s_q.ack;
    wdat = lane_merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);
    widx = wdat[11:8];
    load_lo = do_wr && wb_req_i.adr == `AQT_OFS_ADDR_LOW && wb_req_i.sel[0];
    load_hi = do_wr && wb_req_i.adr == `AQT_OFS_ADDR_HIGH && wb_req_i.sel[0];
    s_d.ack = req && !s_q.ack;
    s_d.rdat = 32'h0000_0000;
    case (wb_req_i.adr)
      `AQT_OFS_CTRL: s_d.rdat[`AQT_CTRL_W-1:0] = s_q.ctrl;
      `AQT_OFS_PAT_START: s_d.rdat[`AQT_PROBE_W-1:0] = s_q.pat_start;
      `AQT_OFS_PAT_STOP: s_d.rdat[`AQT_PROBE_W-1:0] = s_q.pat_stop;
      `AQT_OFS_PAT_RESET: s_d.rdat[`AQT_PROBE_W-1:0] = s_q.pat_reset;
      `AQT_OFS_PAT_ALT: s_d.rdat[`AQT_PROBE_W-1:0] = s_q.pat_alt;
      `AQT_OFS_PAT_STACK: s_d.rdat[`AQT_PROBE_W-1:0] = s_q.pat_stack;
      `AQT_OFS_CARE: s_d.rdat[`AQT_PROBE_W-1:0] = s_q.care;
      `AQT_OFS_ADDR_LOW: s_d.rdat[7:0] = s_q.addr[7:0]; // R9
      `AQT_OFS_ADDR_HIGH: s_d.rdat[7:0] = {s_q.full, s_q.storing, s_q.level,
                                           s_q.addr[9:8]}; // R9
      `AQT_OFS_OCC_LOW: s_d.rdat[`AQT_OCC_W-1:0] = s_q.occ;
      `AQT_OFS_STATUS: s_d.rdat[8:0] = {stack_match, alt_hit, stop_hit, start_hit,
                                        reset_hit, s_q.phase, !irq_request_n_o,
                                        s_q.restart_flag}; // R5 R13
      `AQT_OFS_COUNT: s_d.rdat[`AQT_CNT_W-1:0] = s_q.count;
      `AQT_OFS_DELAY: s_d.rdat[`AQT_ADDR_W-1:0] = s_q.delay_preset;
      default: s_d.rdat = 32'h0000_0000;
    endcase
    mrg = 32'h0000_0000;
    if (do_wr) begin
      case (wb_req_i.adr)
        `AQT_OFS_CTRL: begin
          mrg = lane_merge({20'h0_0000, s_q.ctrl}, wb_req_i.dat, wb_req_i.sel);
          s_d.ctrl = mrg[`AQT_CTRL_W-1:0];
        end
        `AQT_OFS_PAT_START: begin
          mrg = lane_merge({8'h00, s_q.pat_start}, wb_req_i.dat, wb_req_i.sel);
          s_d.pat_start = mrg[`AQT_PROBE_W-1:0];
        end
        `AQT_OFS_PAT_STOP: begin
          mrg = lane_merge({8'h00, s_q.pat_stop}, wb_req_i.dat, wb_req_i.sel);
          s_d.pat_stop = mrg[`AQT_PROBE_W-1:0];
        end
        `AQT_OFS_PAT_RESET: begin
          mrg = lane_merge({8'h00, s_q.pat_reset}, wb_req_i.dat, wb_req_i.sel);
          s_d.pat_reset = mrg[`AQT_PROBE_W-1:0];
        end
        `AQT_OFS_PAT_ALT: begin
          mrg = lane_merge({8'h00, s_q.pat_alt}, wb_req_i.dat, wb_req_i.sel);
          s_d.pat_alt = mrg[`AQT_PROBE_W-1:0];
        end
        `AQT_OFS_PAT_STACK: begin
          mrg = lane_merge({8'h00, s_q.pat_stack}, wb_req_i.dat, wb_req_i.sel);
          s_d.pat_stack = mrg[`AQT_PROBE_W-1:0];
        end
        `AQT_OFS_CARE: begin
          mrg = lane_merge({8'h00, s_q.care}, wb_req_i.dat, wb_req_i.sel);
          s_d.care = mrg[`AQT_PROBE_W-1:0];
        end
        `AQT_OFS_OCC_LOW: begin
          if (wb_req_i.sel[0]) begin
            s_d.occ_ram[widx][7:0] = wdat[7:0]; // R20
          end
        end
        `AQT_OFS_OCC_HIGH: begin
          if (wb_req_i.sel[0]) begin
            s_d.occ_ram[widx][11:8] = wdat[3:0]; // R20
          end
        end
        `AQT_OFS_DELAY: s_d.delay_preset = wdat[`AQT_ADDR_W-1:0];
        default: s_d.delay_preset = s_d.delay_preset;
      endcase
    end

    // ========================================================================
    // Capture address counter
    // ========================================================================
    if (s_q.addr == `AQT_ADDR_MAX && write_en) begin
      s_d.full = 1'b1; // R25
    end
    if (load_lo || load_hi) begin
      if (load_lo) begin
        s_d.addr[7:0] = wdat[7:0]; // R7
        s_d.full = 1'b0;
      end
      if (load_hi) begin
        s_d.addr[9:8] = wdat[1:0]; // R7
      end
    end else if (advance) begin
      s_d.addr = s_q.addr + 10'h001; // R6 R8
    end

    // ========================================================================
    // Stack recognizer, occurrence counter and trigger
    // ========================================================================
    s_d.arm_gate = run && (s_q.arm_gate || external_arm_input_i); // R16
    stack_hit = armed && s_q.arm_gate && stack_match; // R16
    alt_trig = armed && normal && alt_hit; // R22
    reset_evt = armed && normal && reset_hit;
    stack_trig = 1'b0;
    next_lvl = s_q.level + 4'h1;
    if (reset_evt) begin
      s_d.level = '0; // R24
      s_d.occ = s_q.occ_ram[0]; // R19
    end else if (stack_hit) begin
      if (s_q.occ == '0) begin
        if (s_q.level == s_q.ctrl[11:8]) begin
          // Blocking only masks the stack path; the alternate path still fires.
          stack_trig = !s_q.ctrl[`AQT_CTRL_BLOCK]; // R18
        end else begin
          s_d.level = next_lvl;
          s_d.occ = s_q.occ_ram[next_lvl];
        end
      end else begin
        s_d.occ = s_q.occ - 12'h001;
      end
    end
    if (do_wr && wb_req_i.adr == `AQT_OFS_CMD && wb_req_i.sel[0]) begin
      if (wdat[`AQT_CMD_OCC_LOAD]) begin
        s_d.occ = s_q.occ_ram[s_q.level]; // R21
      end else if (wdat[`AQT_CMD_OCC_STEP]) begin
        s_d.occ = s_q.occ - 12'h001; // R21
      end
    end

    case (s_q.phase)
      aqt_pkg::AQT_PH_IDLE: begin
        if (run) begin
          s_d.phase = aqt_pkg::AQT_PH_ARMED;
        end
      end
      aqt_pkg::AQT_PH_ARMED: begin
        if (!run) begin
          s_d.phase = aqt_pkg::AQT_PH_IDLE;
        end else if (stack_trig || alt_trig) begin
          s_d.phase = aqt_pkg::AQT_PH_POST;
          s_d.delay_cnt = s_q.delay_preset;
        end
      end
      aqt_pkg::AQT_PH_POST: begin
        if (s_q.delay_cnt == '0) begin
          s_d.phase = aqt_pkg::AQT_PH_DONE;
        end else begin
          s_d.delay_cnt = s_q.delay_cnt - 10'h001;
        end
      end
      default: s_d.phase = aqt_pkg::AQT_PH_DONE;
    endcase

    // ========================================================================
    // Counter/timer and interrupt latch
    // ========================================================================
    count_inc = (timer_mode && armed) || (counter_mode && stack_hit); // R12
    overflow = count_inc && s_q.count == `AQT_CNT_MAX;
    restart_evt = reset_evt && ct_on;
    if (restart_evt) begin
      s_d.count = '0;
    end else if (count_inc) begin
      s_d.count = s_q.count + 16'h0001;
    end
    if (do_wr && wb_req_i.adr == `AQT_OFS_CMD && wb_req_i.sel[0]) begin
      if (wdat[`AQT_CMD_COUNT_CLEAR]) begin
        s_d.count = '0; // R11
      end
      if (wdat[`AQT_CMD_IRQ_CLEAR]) begin
        s_d.restart_flag = 1'b0; // R14
        s_d.irq_latch = 1'b0; // R14
      end
      if (wdat[`AQT_CMD_REARM]) begin
        s_d.phase = aqt_pkg::AQT_PH_IDLE;
        s_d.level = '0;
      end
    end
    // New events are applied after the clear so that set wins.
    if (restart_evt && timer_mode) begin
      s_d.restart_flag = 1'b1; // R13
    end
    if (overflow || (restart_evt && timer_mode)) begin
      s_d.irq_latch = 1'b1;
    end
  end

  // All state moves on the one clock; single-stepping is the host's job. R26
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdat;
  assign capture_addr_bits_o = s_q.addr; // R8
  assign mem_we_o = write_en; // R3 R4
  assign storage_start_o = start_cond; // R4
  assign storage_stop_n_o = !stop_cond; // R3
  assign capture_addr_advance_n_o = !advance; // R6
  assign paired_window_to_trigger_n_o = pw_n; // R2
  assign alt_trigger_qual_n_o = !(run && alt_hit);
  assign reload_level0_count_n_o = !reset_evt; // R19
  assign first_sample_o = solo && write_en && !s_q.storing; // R17
  assign triggered_o = s_q.phase == aqt_pkg::AQT_PH_POST ||
                       s_q.phase == aqt_pkg::AQT_PH_DONE;
  assign irq_request_n_o = !(s_q.irq_latch && s_q.ctrl[`AQT_CTRL_IRQ_GATE] && ct_on); // R15

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  addr_advance_step_a: assert property (!capture_addr_advance_n_o && !load_lo && !load_hi // R6
    |=> capture_addr_bits_o == $past(capture_addr_bits_o) + 10'h001)
    else $error("address did not step after advance enable");
  stop_blocks_write_a: assert property (!storage_stop_n_o |-> !mem_we_o) // R3
    else $error("write while stop qualification low");
  start_allows_write_a: assert property (storage_start_o && storage_stop_n_o |-> mem_we_o) // R4
    else $error("start qualification did not allow a write");
  paired_alt_stop_a: assert property (pw && run && alt_hit |-> !storage_stop_n_o // R1
    && alt_trigger_qual_n_o == 1'b0)
    else $error("paired window alternate word did not stop storage");
  storing_hold_a: assert property (s_q.storing && storage_stop_n_o |=> s_q.storing) // R23
    else $error("storing dropped without a stop word");
  full_flag_set_a: assert property (capture_addr_bits_o == `AQT_ADDR_MAX && mem_we_o // R25
    && !load_lo |=> s_q.full)
    else $error("full flag missing after last location");
  irq_gate_low_a: assert property (!s_q.ctrl[`AQT_CTRL_IRQ_GATE] |-> irq_request_n_o) // R15
    else $error("interrupt request with gate low");
  irq_clear_works_a: assert property (do_wr && wb_req_i.adr == `AQT_OFS_CMD // R14
    && wb_req_i.sel[0] && wdat[`AQT_CMD_IRQ_CLEAR] && !restart_evt && !overflow
    |=> !s_q.restart_flag && irq_request_n_o)
    else $error("interrupt clear left flag or request set");
  first_sample_solo_a: assert property (!solo |-> !first_sample_o) // R17
    else $error("first sample forwarded outside solo mode");
  reset_level_zero_a: assert property (reset_evt |=> s_q.level == '0 // R24
    && s_q.occ == $past(s_q.occ_ram[0]))
    else $error("reset word did not return to level zero");
  timer_restart_a: assert property (restart_evt && timer_mode |=> s_q.restart_flag // R13
    && s_q.count == '0)
    else $error("timer restart not flagged");
  block_stack_a: assert property (s_q.ctrl[`AQT_CTRL_BLOCK] && !alt_trig // R18
    && armed && run |=> s_q.phase != aqt_pkg::AQT_PH_POST)
    else $error("stack trigger fired while blocked");
  occ_load_a: assert property (do_wr && wb_req_i.adr == `AQT_OFS_CMD && wb_req_i.sel[0] // R21
    && wdat[`AQT_CMD_OCC_LOAD] |=> s_q.occ == $past(s_q.occ_ram[s_q.level]))
    else $error("occurrence load did not copy the stored count");

endmodule

// ==== include/aqt_map.svh ====
/*
  Register offsets, field positions, widths and limits of the acquisition
  qualify and trigger block. Assumes inclusion by bare name from the package.
*/
`ifndef AQT_MAP_SVH
`define AQT_MAP_SVH

`define AQT_PROBE_W 24
`define AQT_ADDR_W 10
`define AQT_OCC_W 12
`define AQT_LVL_W 4
`define AQT_LEVELS 16
`define AQT_CNT_W 16
`define AQT_CTRL_W 12
`define AQT_ADDR_MAX 10'h3FF
`define AQT_CNT_MAX 16'hFFFF

`define AQT_OFS_CTRL 8'h00
`define AQT_OFS_PAT_START 8'h04
`define AQT_OFS_PAT_STOP 8'h08
`define AQT_OFS_PAT_RESET 8'h0C
`define AQT_OFS_PAT_ALT 8'h10
`define AQT_OFS_PAT_STACK 8'h14
`define AQT_OFS_ADDR_LOW 8'h18
`define AQT_OFS_ADDR_HIGH 8'h1C
`define AQT_OFS_OCC_LOW 8'h20
`define AQT_OFS_OCC_HIGH 8'h24
`define AQT_OFS_CMD 8'h28
`define AQT_OFS_STATUS 8'h2C
`define AQT_OFS_COUNT 8'h30
`define AQT_OFS_DELAY 8'h34
`define AQT_OFS_CARE 8'h38

`define AQT_CTRL_PW 0
`define AQT_CTRL_IRQ_GATE 1
`define AQT_CTRL_SEL_A 2
`define AQT_CTRL_SEL_B 3
`define AQT_CTRL_BLOCK 4
`define AQT_CTRL_SOLO 5
`define AQT_CTRL_MEM_READ 6
`define AQT_CTRL_RUN 7

`define AQT_CMD_COUNT_CLEAR 0
`define AQT_CMD_IRQ_CLEAR 1
`define AQT_CMD_OCC_LOAD 2
`define AQT_CMD_OCC_STEP 3
`define AQT_CMD_REARM 4

`endif

// ==== include/aqt_pkg.sv ====
/*
  Types of the acquisition qualify and trigger block: bus carriers, the run
  phase and the complete state record. Assumes aqt_map.svh on the include path.
*/
`include "aqt_map.svh"

package aqt_pkg;

  typedef enum logic [1:0] {
    AQT_PH_IDLE = 2'b00,
    AQT_PH_ARMED = 2'b01,
    AQT_PH_POST = 2'b10,
    AQT_PH_DONE = 2'b11
  } aqt_phase_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } aqt_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } aqt_wb_rsp_t;

  typedef struct packed {
    logic [`AQT_CTRL_W-1:0] ctrl;
    logic [`AQT_PROBE_W-1:0] pat_start, pat_stop, pat_reset, pat_alt, pat_stack, care;
    logic [`AQT_ADDR_W-1:0] addr;
    logic full;
    logic storing;
    aqt_phase_t phase;
    logic [`AQT_LVL_W-1:0] level;
    logic [`AQT_OCC_W-1:0] occ;
    logic [`AQT_LEVELS-1:0][`AQT_OCC_W-1:0] occ_ram;
    logic [`AQT_CNT_W-1:0] count;
    logic restart_flag;
    logic irq_latch;
    logic arm_gate;
    logic [`AQT_ADDR_W-1:0] delay_preset, delay_cnt;
    logic ack;
    logic [31:0] rdat;
  } aqt_state_t;

endpackage

// ==== tb/aqt_host.sv ====
/*
  Host model: a classic Wishbone master that reaches the registers of the
  qualify and trigger block. Assumes one clock shared with the slave.
*/
`timescale 1ns/1ps

module aqt_host (
  input wire logic clk_i,
  input wire aqt_pkg::aqt_wb_rsp_t wb_rsp_i,
  output aqt_pkg::aqt_wb_req_t wb_req_o
);
  // ==========================================================
  // Bus cycles
  initial wb_req_o = '0;

  // The request stands until ack is sampled high. Only the bench watchdog
  // ends the wait on a slave that never answers.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: wd};
    do begin
      @(posedge clk_i);
    end while (wb_rsp_i.ack !== 1'h1);
    rd = wb_rsp_i.dat;
    wb_req_o <= '0;
  endtask
endmodule

// ==== tb/aqt_core_test.sv ====
/*
  Self-checking bench of the acquisition qualify and trigger block.
  Assumes the host model drives the register bus and the bench the probes.
*/
`timescale 1ns/1ps
`include "aqt_map.svh"

module aqt_core_test;
  // ==========================================================
  // Signals and instances
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [`AQT_PROBE_W-1:0] probe_data_i = 24'h000000;
  logic external_arm_input_i = 1'h0;
  aqt_pkg::aqt_wb_req_t wb_req;
  aqt_pkg::aqt_wb_rsp_t wb_rsp;
  logic [`AQT_ADDR_W-1:0] addr;
  logic we, start, stop_n, adv_n, pw_n, alt_n, reload_n, first, trig, irq_n;
  int failures = 0;
  int checks_done = 0;

  always #2 clk_i = ~clk_i;

  aqt_host host (.clk_i(clk_i), .wb_rsp_i(wb_rsp), .wb_req_o(wb_req));

  aqt_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .probe_data_i(probe_data_i), .external_arm_input_i(external_arm_input_i),
    .capture_addr_bits_o(addr), .mem_we_o(we), .storage_start_o(start),
    .storage_stop_n_o(stop_n), .capture_addr_advance_n_o(adv_n),
    .paired_window_to_trigger_n_o(pw_n), .alt_trigger_qual_n_o(alt_n),
    .reload_level0_count_n_o(reload_n), .first_sample_o(first),
    .triggered_o(trig), .irq_request_n_o(irq_n));

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'h1, a, d, r);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'h0, a, 32'h0, d);
    #1;
  endtask

  task automatic probe(input logic [23:0] v);
    @(posedge clk_i);
    probe_data_i <= v;
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_addr;
    logic [31:0] d;
    check("reset addr", 32'(addr), 32'h0);
    check("reset pw_n", 32'(pw_n), 32'h1);
    wr(8'h18, 32'hFE);
    wr(8'h1C, 32'h3);
    check("addr preset", 32'(addr), 32'h3FE);
    rd(8'h18, d);
    check("addr low", d, 32'hFE);
    rd(8'h1C, d);
    check("addr high", 32'(d[1:0]), 32'h3);
    $display("done addr");
  endtask

  task automatic t_store;
    logic [31:0] d;
    logic [`AQT_ADDR_W-1:0] a;
    wr(8'h38, 32'hFFFFFF);
    wr(8'h04, 32'h111111);
    wr(8'h08, 32'h222222);
    wr(8'h0C, 32'h333333);
    wr(8'h10, 32'h444444);
    wr(8'h00, 32'hA0);
    probe(24'h111111);
    check("start", 32'(start), 32'h1);
    check("we", 32'(we), 32'h1);
    check("first", 32'(first), 32'h1);
    check("adv_n", 32'(adv_n), 32'h0);
    probe(24'h000000);
    check("addr step", 32'(addr), 32'h3FF);
    rd(8'h1C, d);
    check("storing full", 32'(d[7:6]), 32'h3);
    probe(24'h222222);
    check("stop_n", 32'(stop_n), 32'h0);
    check("we stop", 32'(we), 32'h0);
    a = addr;
    probe(24'h000000);
    repeat (2) @(posedge clk_i);
    #1;
    check("addr hold", 32'(addr), 32'(a));
    rd(8'h1C, d);
    check("storing off", 32'(d[6]), 32'h0);
    $display("done store");
  endtask

  task automatic t_paired;
    wr(8'h00, 32'h81);
    check("pw_n", 32'(pw_n), 32'h0);
    probe(24'h333333);
    check("pw start", 32'(start), 32'h1);
    check("pw first", 32'(first), 32'h0);
    probe(24'h444444);
    check("pw stop_n", 32'(stop_n), 32'h0);
    probe(24'h000000);
    $display("done paired");
  endtask

  task automatic t_irq;
    logic [31:0] d;
    wr(8'h00, 32'h8E);
    probe(24'h333333);
    check("reload_n", 32'(reload_n), 32'h0);
    probe(24'h000000);
    @(posedge clk_i);
    #1;
    check("irq on", 32'(irq_n), 32'h0);
    rd(8'h2C, d);
    check("restart flag", 32'(d[0]), 32'h1);
    rd(8'h1C, d);
    check("level zero", 32'(d[5:2]), 32'h0);
    wr(8'h00, 32'h8C);
    check("irq gated", 32'(irq_n), 32'h1);
    wr(8'h00, 32'h8E);
    check("irq back", 32'(irq_n), 32'h0);
    wr(8'h28, 32'h2);
    check("irq clear", 32'(irq_n), 32'h1);
    rd(8'h2C, d);
    check("flag clear", 32'(d[0]), 32'h0);
    wr(8'h00, 32'h88);
    wr(8'h28, 32'h1);
    rd(8'h30, d);
    check("count", d, 32'h0);
    $display("done irq");
  endtask

  task automatic t_alt;
    logic [`AQT_ADDR_W-1:0] a;
    wr(8'h00, 32'h90);
    probe(24'h444444);
    check("alt_n", 32'(alt_n), 32'h0);
    probe(24'h000000);
    repeat (3) @(posedge clk_i);
    #1;
    check("triggered", 32'(trig), 32'h1);
    wr(8'h00, 32'hD0);
    check("read adv_n", 32'(adv_n), 32'h0);
    a = addr;
    @(posedge clk_i);
    #1;
    check("read step", 32'(addr), 32'(a + 10'h001));
    $display("done alt");
  endtask

  task automatic t_stack;
    logic [31:0] d;
    wr(8'h00, 32'h188);
    wr(8'h14, 32'h555555);
    wr(8'h20, 32'h001);
    wr(8'h20, 32'h100);
    wr(8'h24, 32'h101);
    wr(8'h28, 32'h14);
    probe(24'h555555);
    probe(24'h000000);
    rd(8'h20, d);
    check("occ gated", d, 32'h1);
    @(posedge clk_i);
    external_arm_input_i <= 1'h1;
    @(posedge clk_i);
    external_arm_input_i <= 1'h0;
    probe(24'h555555);
    @(posedge clk_i);
    probe(24'h000000);
    rd(8'h1C, d);
    check("stack level", 32'(d[5:2]), 32'h1);
    rd(8'h20, d);
    check("occ level1", d, 32'h100);
    rd(8'h30, d);
    check("event count", d, 32'h2);
    probe(24'h333333);
    check("reload_n stack", 32'(reload_n), 32'h0);
    probe(24'h000000);
    rd(8'h1C, d);
    check("level back", 32'(d[5:2]), 32'h0);
    rd(8'h20, d);
    check("occ level0", d, 32'h1);
    rd(8'h2C, d);
    check("no timer flag", 32'(d[0]), 32'h0);
    wr(8'h00, 32'h198);
    probe(24'h555555);
    repeat (300) @(posedge clk_i);
    #1;
    check("blocked", 32'(trig), 32'h0);
    wr(8'h00, 32'h188);
    @(posedge clk_i);
    #1;
    check("stack trig", 32'(trig), 32'h1);
    probe(24'h000000);
    $display("done stack");
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    #80000;
    failures++;
    stop_test;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    t_addr;
    t_store;
    t_paired;
    t_irq;
    t_alt;
    t_stack;
    stop_test;
  end
endmodule
